// ===== verification/tpsu_bench.sv
`timescale 1ns/10ps
// ==========================================
// Self-checking bench for the timer output and sync unit
module tpsu_bench;
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d, e;
  } tpsu_reg_row_t;
  typedef struct packed {
    logic [15:0] ctrl, cmp;
    logic [2:0]  om;
    logic [31:0] e;
  } tpsu_pwm_row_t;
  typedef struct packed {
    logic [15:0] ctrl, ms, psc;
    logic        run, pulse, halt;
    logic [31:0] e;
  } tpsu_rate_row_t;

  logic        clk_in = 1'b0, reset_n_in = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        ti1 = 1'b0, ti2 = 1'b0, etr = 1'b0, halt = 1'b0, prun = 1'b0, ppulse = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdata, c1, highs;
  logic        hready, hresp, mtrig, ref_lvl, chan, trigger_output, cen;
  int          compares = 0, miscompares = 0, cycles = 0, n;

  // Register rows: reset values, read-back, unmapped place
  tpsu_reg_row_t  rr[8] = '{'{8'h1c, 1'b0, 32'h0, 32'hffff},
                            '{8'h00, 1'b0, 32'h0, 32'h0},
                            '{8'h20, 1'b1, 32'h1234, 32'h1234},
                            '{8'h18, 1'b1, 32'h5, 32'h5},
                            '{8'h40, 1'b1, 32'hffffffff, 32'h0},
                            '{8'h08, 1'b1, 32'h3fc, 32'h3fc},
                            '{8'h08, 1'b1, 32'h0, 32'h0},
                            '{8'h18, 1'b1, 32'h0, 32'h0}};
  // High cycles of the reference in 24 cycles, reload 3
  tpsu_pwm_row_t  pw[9] = '{'{16'h01, 16'h1, 3'h6, 32'h6}, '{16'h01, 16'h1, 3'h7, 32'h12},
                            '{16'h01, 16'h5, 3'h6, 32'h18}, '{16'h01, 16'h0, 3'h6, 32'h0},
                            '{16'h11, 16'h1, 3'h6, 32'hc}, '{16'h11, 16'h5, 3'h6, 32'h18},
                            '{16'h21, 16'h2, 3'h6, 32'h10}, '{16'h41, 16'h2, 3'h7, 32'h8},
                            '{16'h61, 16'h2, 3'h6, 32'h10}};
  // Counts gained over 20 cycles
  tpsu_rate_row_t rt[7] = '{'{16'h001, 16'h200, 16'h0, 1'b0, 1'b0, 1'b0, 32'h14},
                            '{16'h001, 16'h0, 16'h1, 1'b0, 1'b0, 1'b0, 32'ha},
                            '{16'h101, 16'h0, 16'h0, 1'b0, 1'b0, 1'b1, 32'h0},
                            '{16'h001, 16'h0, 16'h0, 1'b0, 1'b0, 1'b1, 32'h14},
                            '{16'h001, 16'h5, 16'h0, 1'b0, 1'b0, 1'b0, 32'h0},
                            '{16'h001, 16'h5, 16'h1, 1'b1, 1'b0, 1'b0, 32'ha},
                            '{16'h001, 16'h7, 16'h0, 1'b1, 1'b1, 1'b0, 32'h4}};
  // Center-mode counter writes: value written, control read-back
  logic [63:0]    cw[3] = '{{32'h3, 32'h30}, {32'h9, 32'h30}, {32'h0, 32'h20}};

  always #25 clk_in = ~clk_in;

  tpsu_top tpsu_top_i (
    .clk_in                  (clk_in),
    .reset_n_in              (reset_n_in),
    .hsel_in                 (hsel),
    .haddr_in                (haddr),
    .htrans_in               (htrans),
    .hwrite_in               (hwrite),
    .hsize_in                (3'h2),
    .hwdata_in               (hwdata),
    .hready_in               (hready),
    .hrdata_out              (hrdata),
    .hreadyout_out           (hready),
    .hresp_out               (hresp),
    .timer_input_one_in      (ti1),
    .filtered_input_two_in   (ti2),
    .filtered_ext_trigger_in (etr),
    .master_trigger_in       (mtrig),
    .debug_halt_in           (halt),
    .channel_reference_out   (ref_lvl),
    .channel_out             (chan),
    .trigger_output_out      (trigger_output),
    .counter_enable_out      (cen)
  );

  tpsu_partner tpsu_partner_i (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .run_in     (prun),
    .pulse_in   (ppulse),
    .trig_out   (mtrig)
  );

  // ==========================================
  // Bus cycles and comparisons
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    rdata = hrdata;
  endtask : bus

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // Hang guard, well above the expected run length
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    foreach (rr[i]) begin
      if (rr[i].w) begin
        bus(rr[i].a, 1'b1, rr[i].d);
      end
      bus(rr[i].a, 1'b0, 32'h0);
      chk(rdata, rr[i].e);
    end
    chk_bit(hresp, 1'b0);
    $display("registers done");
    bus(tpsu_pkg::A_RELOAD, 1'b1, 32'h3);
    bus(tpsu_pkg::A_MSCFG, 1'b1, 32'h100);
    foreach (pw[i]) begin
      bus(tpsu_pkg::A_CTRL, 1'b1, 32'h0);
      bus(tpsu_pkg::A_CMP, 1'b1, {16'h0, pw[i].cmp});
      bus(tpsu_pkg::A_CHCFG, 1'b1, {25'h0, pw[i].om, 4'h8});
      bus(tpsu_pkg::A_EVT, 1'b1, 32'h1);
      bus(tpsu_pkg::A_STATUS, 1'b1, 32'h0);
      bus(tpsu_pkg::A_CTRL, 1'b1, {16'h0, pw[i].ctrl});
      repeat (8) @(posedge clk_in);
      highs = 32'h0;
      repeat (24) begin
        @(negedge clk_in);
        highs += {31'h0, ref_lvl === 1'b1};
      end
      chk(highs, pw[i].e);
      chk_bit(trigger_output, 1'b1);
      @(posedge clk_in);
    end
    $display("pwm waveforms done");
    bus(tpsu_pkg::A_CTRL, 1'b1, 32'h0);
    bus(tpsu_pkg::A_RELOAD, 1'b1, 32'h5);
    bus(tpsu_pkg::A_CMP, 1'b1, 32'h2);
    bus(tpsu_pkg::A_MSCFG, 1'b1, 32'h66);
    for (int k = 0; k < 2; k++) begin
      bus(tpsu_pkg::A_CHCFG, 1'b1, (k == 1) ? 32'h7c : 32'h78);
      bus(tpsu_pkg::A_EVT, 1'b1, 32'h1);
      bus(tpsu_pkg::A_STATUS, 1'b1, 32'h0);
      bus(tpsu_pkg::A_CTRL, 1'b1, 32'h8);
      ti2 <= 1'b1;
      n = 0;
      do begin
        @(negedge clk_in);
        n++;
      end while (cen !== 1'b1 && n < 10);
      chk_bit(cen, 1'b1);
      @(negedge clk_in);
      // Fast enable must already show the match level here
      chk_bit(ref_lvl, k[0]);
      highs = 32'h0;
      repeat (16) begin
        @(negedge clk_in);
        highs += {31'h0, ref_lvl === 1'b1};
      end
      // Pulse spans counts from compare up to reload inclusive
      if (k == 0) begin
        chk(highs, 32'h4);
      end
      chk_bit(cen, 1'b0);
      @(posedge clk_in);
      ti2 <= 1'b0;
      bus(tpsu_pkg::A_STATUS, 1'b0, 32'h0);
      chk(rdata & 32'h40, 32'h40);
    end
    $display("single pulse done");
    bus(tpsu_pkg::A_MSCFG, 1'b1, 32'h0);
    bus(tpsu_pkg::A_RELOAD, 1'b1, 32'h3);
    bus(tpsu_pkg::A_CMP, 1'b1, 32'h5);
    for (int k = 0; k < 2; k++) begin
      bus(tpsu_pkg::A_CTRL, 1'b1, 32'h0);
      bus(tpsu_pkg::A_CHCFG, 1'b1, (k == 1) ? 32'h3d8 : 32'h2e8);
      bus(tpsu_pkg::A_EVT, 1'b1, 32'h1);
      bus(tpsu_pkg::A_CTRL, 1'b1, 32'h1);
      repeat (6) @(posedge clk_in);
      etr <= 1'b1;
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      chk_bit(ref_lvl, k[0]);
      chk_bit(chan, 1'b0);
      @(posedge clk_in);
      etr <= 1'b0;
      repeat (12) @(posedge clk_in);
      @(negedge clk_in);
      chk_bit(ref_lvl, 1'b1);
      chk_bit(chan, ~k[0]);
      @(posedge clk_in);
    end
    $display("external clear done");
    bus(tpsu_pkg::A_RELOAD, 1'b1, 32'hffff);
    bus(tpsu_pkg::A_CHCFG, 1'b1, 32'h0);
    foreach (rt[i]) begin
      bus(tpsu_pkg::A_CTRL, 1'b1, 32'h0);
      bus(tpsu_pkg::A_MSCFG, 1'b1, {16'h0, rt[i].ms});
      bus(tpsu_pkg::A_PSC, 1'b1, {16'h0, rt[i].psc});
      bus(tpsu_pkg::A_EVT, 1'b1, 32'h1);
      halt <= rt[i].halt;
      bus(tpsu_pkg::A_CTRL, 1'b1, {16'h0, rt[i].ctrl});
      prun   <= rt[i].run;
      ppulse <= rt[i].pulse;
      repeat (6) @(posedge clk_in);
      bus(tpsu_pkg::A_CNT, 1'b0, 32'h0);
      c1 = rdata;
      repeat (18) @(posedge clk_in);
      bus(tpsu_pkg::A_CNT, 1'b0, 32'h0);
      chk(rdata - c1, rt[i].e);
      prun <= 1'b0;
      halt <= 1'b0;
    end
    $display("counter rates done");
    bus(tpsu_pkg::A_RELOAD, 1'b1, 32'h3);
    bus(tpsu_pkg::A_CTRL, 1'b1, 32'h20);
    bus(tpsu_pkg::A_STATUS, 1'b1, 32'h0);
    foreach (cw[i]) begin
      bus(tpsu_pkg::A_CNT, 1'b1, cw[i][63:32]);
      bus(tpsu_pkg::A_CTRL, 1'b0, 32'h0);
      chk(rdata, cw[i][31:0]);
    end
    bus(tpsu_pkg::A_STATUS, 1'b0, 32'h0);
    chk(rdata & 32'h1, 32'h0);
    $display("center writes done");
    bus(tpsu_pkg::A_CTRL, 1'b1, 32'h0);
    bus(tpsu_pkg::A_MSCFG, 1'b1, 32'h1c6);
    bus(tpsu_pkg::A_STATUS, 1'b1, 32'h0);
    ti1 <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (trigger_output !== 1'b1 && n < 10);
    // Enable output leads the delayed master start by one cycle
    chk_bit(trigger_output, 1'b1);
    chk_bit(cen, 1'b0);
    @(negedge clk_in);
    chk_bit(cen, 1'b1);
    @(posedge clk_in);
    bus(tpsu_pkg::A_STATUS, 1'b0, 32'h0);
    chk(rdata & 32'h40, 32'h40);
    $display("sync start done");
    reset_n_in <= 1'b0;
    @(negedge clk_in);
    chk({27'h0, hready, cen, trigger_output, chan, ref_lvl}, 32'h10);
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    bus(tpsu_pkg::A_RELOAD, 1'b0, 32'h0);
    chk(rdata, 32'hffff);
    $display("reset done");
    end_of_test();
  end
endmodule : tpsu_bench

// ===== verification/tpsu_partner.sv
`timescale 1ns/10ps
// ==========================================
// Neighbouring timer on the trigger interconnect
module tpsu_partner #(
  parameter int PERIOD = 5
) (
  input  wire logic clk_in,     // Shared kernel clock
  input  wire logic reset_n_in, // Async reset, active low
  input  wire logic run_in,     // Neighbour counter enabled
  input  wire logic pulse_in,   // 1: update pulses, 0: enable level
  output logic      trig_out    // Neighbour trigger output
);
  int unsigned cnt_reg;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_reg  <= 0;
      trig_out <= 1'b0;
    end else begin
      cnt_reg  <= (run_in && cnt_reg < PERIOD - 1) ? cnt_reg + 1 : 0;
      // pulse per period or enable level
      trig_out <= pulse_in ? (run_in && cnt_reg == PERIOD - 1) : run_in;
    end
  end
endmodule : tpsu_partner

// ===== verilog/tpsu_pkg.sv
package tpsu_pkg;
  localparam int CW = 16;
  // ==========================================
  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_MSCFG  = 8'h04;
  localparam logic [7:0] A_CHCFG  = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0c;
  localparam logic [7:0] A_EVT    = 8'h10;
  localparam logic [7:0] A_CNT    = 8'h14;
  localparam logic [7:0] A_PSC    = 8'h18;
  localparam logic [7:0] A_RELOAD = 8'h1c;
  localparam logic [7:0] A_CMP    = 8'h20;
  // ==========================================
  // Field positions
  localparam int B_CEN  = 0;
  localparam int B_SPM  = 3;
  localparam int B_DIR  = 4;
  localparam int B_CAS  = 5;
  localparam int B_ARPE = 7;
  localparam int B_DBG  = 8;
  localparam int B_SMS  = 0;
  localparam int B_TSS  = 4;
  localparam int B_MSS  = 7;
  localparam int B_MMS  = 8;
  localparam int B_FAST = 2;
  localparam int B_CPE  = 3;
  localparam int B_OM   = 4;
  localparam int B_ECE  = 7;
  localparam int B_POL  = 8;
  localparam int B_OE   = 9;
  localparam int B_UIF  = 0;
  localparam int B_CCF  = 1;
  localparam int B_TIF  = 6;
  localparam int B_UG   = 0;
  // ==========================================
  // Mode codes
  localparam logic [2:0] OM_ACT  = 3'h1;
  localparam logic [2:0] OM_INA  = 3'h2;
  localparam logic [2:0] OM_TOG  = 3'h3;
  localparam logic [2:0] OM_FLO  = 3'h4;
  localparam logic [2:0] OM_FHI  = 3'h5;
  localparam logic [2:0] OM_PWM1 = 3'h6;
  localparam logic [2:0] OM_PWM2 = 3'h7;
  localparam logic [2:0] SM_GATE = 3'h5;
  localparam logic [2:0] SM_TRIG = 3'h6;
  localparam logic [2:0] SM_EXT1 = 3'h7;
  localparam logic [2:0] TS_ITR  = 3'h0;
  localparam logic [2:0] TS_TI1E = 3'h4;
  localparam logic [2:0] TS_TI2  = 3'h6;
  localparam logic [2:0] MM_EN   = 3'h1;
  localparam logic [2:0] MM_UEV  = 3'h2;
  localparam logic [2:0] MM_CMP  = 3'h3;
  localparam logic [2:0] MM_REF  = 3'h4;
  localparam logic [CW-1:0] RELOAD_RST = 16'hffff;

  typedef struct packed {
    logic          cen, spm, dir, arpe, dbg, mss, fast, cpe, ece, pol, oe;
    logic [1:0]    cas;
    logic [2:0]    sms, tss, mms, om;
    logic          uif, ccf, tif, pend;
    logic [CW-1:0] cnt, psc, pscc, arr_pre, arr_sh, ccr_pre, ccr_sh;
    logic          ref_q, clr, fhold, prev_hi, trigger_input_d, ti1_d;
    logic          ti1_s1, ti1_s2, ti2_s1, ti2_s2;
    logic          etr_s1, etr_s2, dbg_s1, dbg_s2;
    logic          dph_wr, hready, hresp, trigger_output, chan;
    logic [7:0]    dph_addr;
    logic [31:0]   hrdata;
  } tpsu_state_t;

  localparam tpsu_state_t ST_RST = '{arr_pre: RELOAD_RST, arr_sh: RELOAD_RST,
                                     hready: 1'b1, default: '0};
endpackage : tpsu_pkg

// ===== verilog/tpsu_top.sv
`timescale 1ns/10ps
// ==========================================
// Overview of operation
// - Output mode 110 is PWM mode 1, 111 PWM mode 2; compare/reload set duty/period
// - Counter compared against compare shadow on every counter clock
// - With preload, shadows load only on an update event
// - Center-align codes 01, 10, 11 enable center counting; 01 and 10 gate the flag by direction
// - Code 10 flags up-counting only, 11 flags both directions
// - Direction is hardware driven in center-aligned operation
// - Center mode: writing 0 or reload sets direction, no update event
// - Center mode: writing above reload leaves direction unchanged
// - Up PWM1: high while counter below compare; above reload 1, zero gives 0
// - Down PWM1: low while counter above compare; above reload keeps 1
// - Compare 0 after compare at/above reload: no compare event at zero
// - Single-pulse: counter stops and clears enable on next counter-generated update event, not on a software update
// - Single-pulse: compare sets delay, reload minus compare plus one sets width
// - Input two as trigger in trigger mode starts counter on rising edge
// - Fast enable in PWM forces match level at trigger edge
// - External clear drives reference low until next update; not in forced modes
// - Debug halt stops or keeps the counter per debug stop bit
// - Master select routes enable, update or channel reference to trigger output
// - Trigger select 000 internal master trigger, 100 input one edge detector
// - Slave 111 external clock, 101 gated, 110 trigger start
// - Gated mode gates only the counter enable, prescaler keeps running
// - Master/slave sync makes master and slave start together with both flags
module tpsu_top (
  input  wire logic        clk_in,                  // Kernel clock
  input  wire logic        reset_n_in,              // Async reset, active low
  input  wire logic        hsel_in,                 // AHB select
  input  wire logic [31:0] haddr_in,                // AHB address
  input  wire logic [1:0]  htrans_in,               // AHB transfer type
  input  wire logic        hwrite_in,               // AHB write
  input  wire logic [2:0]  hsize_in,                // AHB size
  input  wire logic [31:0] hwdata_in,               // AHB write data
  input  wire logic        hready_in,               // AHB bus ready
  output logic      [31:0] hrdata_out,              // AHB read data
  output logic             hreadyout_out,           // AHB slave ready
  output logic             hresp_out,               // AHB response
  input  wire logic        timer_input_one_in,      // Input one pin
  input  wire logic        filtered_input_two_in,   // Filtered input two
  input  wire logic        filtered_ext_trigger_in, // Filtered external trigger
  input  wire logic        master_trigger_in,       // Master timer trigger output
  input  wire logic        debug_halt_in,           // Core halted in debug
  output logic             channel_reference_out,   // Channel reference
  output logic             channel_out,             // Polarised channel output
  output logic             trigger_output_out,      // Trigger output to slaves
  output logic             counter_enable_out       // Counter enable
);
  tpsu_pkg::tpsu_state_t s;
  tpsu_pkg::tpsu_state_t n;
  logic          update_event, uevc, ug, trigger_input, tedge, tick, run, hit, cev, pwm1, lvl, cntw, halt;
  logic [31:0]   rd;
  logic [15:0]   wd;

  assign hrdata_out            = s.hrdata;
  assign hreadyout_out         = s.hready;
  assign hresp_out             = s.hresp;
  assign channel_reference_out = s.ref_q;
  assign channel_out           = s.chan;
  assign trigger_output_out    = s.trigger_output;
  assign counter_enable_out    = s.cen;

  always_comb begin
    n    = s;
    rd   = '0;
    wd   = hwdata_in[15:0];
    uevc = 1'b0;
    lvl  = s.ref_q;
    // ==========================================
    // Pin synchronisers
    n.ti1_s1 = timer_input_one_in;
    n.ti1_s2 = s.ti1_s1;
    n.ti2_s1 = filtered_input_two_in;
    n.ti2_s2 = s.ti2_s1;
    n.etr_s1 = filtered_ext_trigger_in;
    n.etr_s2 = s.etr_s1;
    n.dbg_s1 = debug_halt_in;
    n.dbg_s2 = s.dbg_s1;
    n.ti1_d  = s.ti1_s2;
    // ==========================================
    // Bus address phase, zero wait states
    n.hready   = 1'b1;
    n.hresp    = 1'b0;
    n.dph_wr   = hsel_in & hready_in & htrans_in[1] & hwrite_in;
    n.dph_addr = haddr_in[7:0];
    unique case (haddr_in[7:0])
      tpsu_pkg::A_CTRL: begin
        rd[tpsu_pkg::B_CEN]      = s.cen;
        rd[tpsu_pkg::B_SPM]      = s.spm;
        rd[tpsu_pkg::B_DIR]      = s.dir;
        rd[tpsu_pkg::B_CAS +: 2] = s.cas;
        rd[tpsu_pkg::B_ARPE]     = s.arpe;
        rd[tpsu_pkg::B_DBG]      = s.dbg;
      end
      tpsu_pkg::A_MSCFG: begin
        rd[tpsu_pkg::B_SMS +: 3] = s.sms;
        rd[tpsu_pkg::B_TSS +: 3] = s.tss;
        rd[tpsu_pkg::B_MSS]      = s.mss;
        rd[tpsu_pkg::B_MMS +: 3] = s.mms;
      end
      tpsu_pkg::A_CHCFG: begin
        rd[tpsu_pkg::B_FAST]    = s.fast;
        rd[tpsu_pkg::B_CPE]     = s.cpe;
        rd[tpsu_pkg::B_OM +: 3] = s.om;
        rd[tpsu_pkg::B_ECE]     = s.ece;
        rd[tpsu_pkg::B_POL]     = s.pol;
        rd[tpsu_pkg::B_OE]      = s.oe;
      end
      tpsu_pkg::A_STATUS: begin
        rd[tpsu_pkg::B_UIF] = s.uif;
        rd[tpsu_pkg::B_CCF] = s.ccf;
        rd[tpsu_pkg::B_TIF] = s.tif;
      end
      tpsu_pkg::A_CNT:    rd[15:0] = s.cnt;
      tpsu_pkg::A_PSC:    rd[15:0] = s.psc;
      tpsu_pkg::A_RELOAD: rd[15:0] = s.arr_pre;
      tpsu_pkg::A_CMP:    rd[15:0] = s.ccr_pre;
      default:            rd = '0;
    endcase
    if (hsel_in && hready_in && htrans_in[1] && !hwrite_in) begin
      n.hrdata = rd;
    end
    // ==========================================
    // Trigger input selection
    // trigger source mux
    unique case (s.tss)
      tpsu_pkg::TS_ITR:  trigger_input = master_trigger_in;
      tpsu_pkg::TS_TI1E: trigger_input = s.ti1_s2 ^ s.ti1_d;
      tpsu_pkg::TS_TI2:  trigger_input = s.ti2_s2;
      default:           trigger_input = 1'b0;
    endcase
    n.trigger_input_d = trigger_input;
    tedge    = trigger_input & ~s.trigger_input_d;
    // ==========================================
    // Data phase writes; status bits clear on 0, hardware sets win below
    cntw = s.dph_wr && s.dph_addr == tpsu_pkg::A_CNT;
    ug   = s.dph_wr && s.dph_addr == tpsu_pkg::A_EVT && hwdata_in[tpsu_pkg::B_UG];
    if (s.dph_wr) begin
      unique case (s.dph_addr)
        tpsu_pkg::A_CTRL: begin
          n.cen  = wd[tpsu_pkg::B_CEN];
          n.spm  = wd[tpsu_pkg::B_SPM];
          n.cas  = wd[tpsu_pkg::B_CAS +: 2];
          n.arpe = wd[tpsu_pkg::B_ARPE];
          n.dbg  = wd[tpsu_pkg::B_DBG];
          if (s.cas == 2'h0) begin
            n.dir = wd[tpsu_pkg::B_DIR];
          end
        end
        tpsu_pkg::A_MSCFG: begin
          n.sms = wd[tpsu_pkg::B_SMS +: 3];
          n.tss = wd[tpsu_pkg::B_TSS +: 3];
          n.mss = wd[tpsu_pkg::B_MSS];
          n.mms = wd[tpsu_pkg::B_MMS +: 3];
        end
        tpsu_pkg::A_CHCFG: begin
          n.fast = wd[tpsu_pkg::B_FAST];
          n.cpe  = wd[tpsu_pkg::B_CPE];
          n.om   = wd[tpsu_pkg::B_OM +: 3];
          n.ece  = wd[tpsu_pkg::B_ECE];
          n.pol  = wd[tpsu_pkg::B_POL];
          n.oe   = wd[tpsu_pkg::B_OE];
        end
        tpsu_pkg::A_STATUS: begin
          n.uif = s.uif & wd[tpsu_pkg::B_UIF];
          n.ccf = s.ccf & wd[tpsu_pkg::B_CCF];
          n.tif = s.tif & wd[tpsu_pkg::B_TIF];
        end
        tpsu_pkg::A_CNT: begin
          n.cnt = wd;
          // direction from 0 or reload, no update
          if (s.cas != 2'h0 && wd == '0) begin
            n.dir = 1'b0;
          end else if (s.cas != 2'h0 && wd == s.arr_sh) begin
            n.dir = 1'b1;
          end
        end
        tpsu_pkg::A_PSC: n.psc = wd;
        tpsu_pkg::A_RELOAD: begin
          n.arr_pre = wd;
          if (!s.arpe) begin
            n.arr_sh = wd;
          end
        end
        tpsu_pkg::A_CMP: begin
          n.ccr_pre = wd;
          if (!s.cpe) begin
            n.ccr_sh = wd;
          end
        end
        default: ;
      endcase
    end
    // ==========================================
    // Slave mode start
    n.pend = 1'b0;
    if (s.sms != 3'h0 && tedge) begin
      if (s.sms == tpsu_pkg::SM_TRIG && s.mss) begin
        n.pend = 1'b1;
      end else begin
        n.tif = 1'b1;
        if (s.sms == tpsu_pkg::SM_TRIG) begin
          n.cen = 1'b1;
        end
      end
    end
    // master start delayed one cycle to meet slave
    if (s.pend) begin
      n.cen = 1'b1;
      n.tif = 1'b1;
    end
    // ==========================================
    // Prescaler and counter
    // debug halt freeze
    halt = s.dbg_s2 & s.dbg;
    tick = s.pscc >= s.psc;
    if (s.cen && !halt) begin
      n.pscc = tick ? '0 : s.pscc + 16'h1;
    end
    if (s.sms == tpsu_pkg::SM_EXT1) begin
      tick = tedge;
    end
    run = s.cen && !halt && tick && (s.sms != tpsu_pkg::SM_GATE || trigger_input);
    if (run && !cntw) begin
      if (s.cas == 2'h0) begin
        if (!s.dir) begin
          if (s.cnt >= s.arr_sh) begin
            n.cnt = '0;
            uevc  = 1'b1;
          end else begin
            n.cnt = s.cnt + 16'h1;
          end
        end else if (s.cnt == '0) begin
          n.cnt = s.arr_sh;
          uevc  = 1'b1;
        end else begin
          n.cnt = s.cnt - 16'h1;
        end
      // hardware turns direction in center mode
      end else if (!s.dir) begin
        if (s.cnt >= s.arr_sh) begin
          n.dir = 1'b1;
          n.cnt = s.cnt - 16'h1;
          uevc  = 1'b1;
        end else begin
          n.cnt = s.cnt + 16'h1;
        end
      end else if (s.cnt == '0) begin
        n.dir = 1'b0;
        n.cnt = s.cnt + 16'h1;
        uevc  = 1'b1;
      end else begin
        n.cnt = s.cnt - 16'h1;
      end
    end
    // ==========================================
    // Update event
    update_event = uevc | ug;
    if (update_event) begin
      n.uif     = 1'b1;
      n.prev_hi = s.ccr_sh >= s.arr_sh;
      if (s.arpe) begin
        n.arr_sh = s.arr_pre;
      end
      if (s.cpe) begin
        n.ccr_sh = s.ccr_pre;
      end
    end
    // software update restarts count and prescaler
    if (ug) begin
      n.cnt  = '0;
      n.pscc = '0;
    end
    if (s.spm && uevc) begin
      n.cen = 1'b0;
    end
    // ==========================================
    // Compare and reference
    // compare each counter clock
    // delay is compare, width is reload minus compare plus one
    hit = run && s.cnt == s.ccr_sh;
    // no event at zero after high compare
    cev = hit && !(s.ccr_sh == '0 && s.prev_hi) &&
          (s.cas == 2'h0 || s.cas == 2'h3 || (s.cas == 2'h1) == s.dir);
    if (cev) begin
      n.ccf = 1'b1;
    end
    pwm1 = (s.ccr_sh > s.arr_sh) ? 1'b1 :
           (s.dir ? s.cnt <= s.ccr_sh : s.cnt < s.ccr_sh);
    unique case (s.om)
      tpsu_pkg::OM_ACT:  lvl = cev ? 1'b1 : s.ref_q;
      tpsu_pkg::OM_INA:  lvl = cev ? 1'b0 : s.ref_q;
      tpsu_pkg::OM_TOG:  lvl = cev ? ~s.ref_q : s.ref_q;
      tpsu_pkg::OM_FLO:  lvl = 1'b0;
      tpsu_pkg::OM_FHI:  lvl = 1'b1;
      tpsu_pkg::OM_PWM1: lvl = pwm1;
      tpsu_pkg::OM_PWM2: lvl = ~pwm1;
      default:           lvl = s.ref_q;
    endcase
    if (cev || update_event) begin
      n.fhold = 1'b0;
    end
    if (s.fast && s.om[2:1] == 2'h3 && tedge) begin
      n.fhold = 1'b1;
    end
    if (n.fhold) begin
      lvl = s.om == tpsu_pkg::OM_PWM2;
    end
    if (update_event) begin
      n.clr = 1'b0;
    end
    if (s.ece && s.etr_s2 && s.om != tpsu_pkg::OM_FLO && s.om != tpsu_pkg::OM_FHI) begin
      n.clr = 1'b1;
    end
    n.ref_q = lvl & ~n.clr;
    n.chan  = s.oe & (n.ref_q ^ s.pol);
    // ==========================================
    // Trigger output
    // master output select
    unique case (s.mms)
      tpsu_pkg::MM_EN:  n.trigger_output = n.cen | n.pend;
      tpsu_pkg::MM_UEV: n.trigger_output = update_event;
      tpsu_pkg::MM_CMP: n.trigger_output = cev;
      tpsu_pkg::MM_REF: n.trigger_output = n.ref_q;
      3'h5, 3'h6, 3'h7: n.trigger_output = n.ref_q & ~s.ref_q;
      default:          n.trigger_output = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= tpsu_pkg::ST_RST;
    end else begin
      s <= n;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_pwm_high_over: assert property (
    (s.om == tpsu_pkg::OM_PWM1 && s.ccr_sh > s.arr_sh && !n.fhold) |=> (s.ref_q || s.clr))
    else $error("PWM1 not high with compare above reload");
  a_pwm2_inverse: assert property (
    (s.om == tpsu_pkg::OM_PWM2 && !s.dir && s.ccr_sh == '0) |=> (s.ref_q || s.clr))
    else $error("PWM2 not inverse of PWM1");
  a_preload_hold: assert property (
    (s.cpe && !update_event) |=> $stable(s.ccr_sh))
    else $error("compare shadow moved without update");
  a_pulse_stop: assert property (
    (s.spm && uevc && !s.dph_wr && !tedge && !s.pend) |=> !s.cen)
    else $error("single pulse did not stop counter");
  a_center_wr_dir: assert property (
    (cntw && s.cas != 2'h0 && wd == s.arr_sh && wd != '0 && !ug) |=> (s.dir && !$rose(s.uif)))
    else $error("center write of reload mishandled");
  a_clear_low: assert property (
    s.clr |-> !s.ref_q)
    else $error("reference high during external clear");
  a_debug_freeze: assert property (
    (s.dbg_s2 && s.dbg && !cntw && !ug) |=> $stable(s.cnt))
    else $error("counter moved in debug halt");
  a_gate_stop: assert property (
    (s.sms == tpsu_pkg::SM_GATE && !trigger_input && !cntw && !ug) |=> $stable(s.cnt))
    else $error("gated counter moved with gate low");
  a_trig_start: assert property (
    (s.sms == tpsu_pkg::SM_TRIG && tedge && !s.mss) |=> (s.cen && s.tif))
    else $error("trigger did not start counter");
  a_sync_start: assert property (
    (s.sms == tpsu_pkg::SM_TRIG && tedge && s.mss && !s.dph_wr) |=> ##1 (s.cen && s.tif))
    else $error("synchronised start late");
  a_zero_no_flag: assert property (
    (s.prev_hi && s.ccr_sh == '0 && !s.ccf && !update_event) |=> !s.ccf)
    else $error("compare event at zero after high compare");
  a_trigger_output_update: assert property (
    (s.mms == tpsu_pkg::MM_UEV) |=> (s.trigger_output == $past(update_event)))
    else $error("trigger output not update event");
endmodule : tpsu_top
